// ### rtl/fmsp_serial_port.sv
// Four mode serial port core
`timescale 1ns/1ps
`include "fmsp_consts.svh"
module fmsp_serial_port (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic buf_wr_i,
	input wire logic [7:0] buf_wdata_i,
	output logic [7:0] buf_rdata_o,
	input wire logic ctrl_wr_i,
	input wire logic [7:0] ctrl_wdata_i,
	output logic [7:0] ctrl_rdata_o,
	input wire logic rate_double_bit_i,
	input wire logic frame_error_access_select_i,
	input wire logic timer_ovf_i,
	input wire logic rxd_i,
	output logic rxd_o,
	output logic rxd_oe_o,
	output logic txd_o
);
	logic rst_q1;
	logic rst_n;
	logic rx_s1;
	logic rx_s2;
	logic rx_s3;
	logic rx_lvl;
	logic mode_select_high;
	logic mode_select_low;
	logic multiproc_rate_flag;
	logic receive_enable;
	logic transmit_ninth_bit;
	logic receive_ninth_bit;
	logic transmit_done_flag;
	logic receive_done_flag;
	logic frame_error_flag;
	logic [7:0] serial_buffer;
	fmsp_pkg::fmsp_sync_st_t sy_st;
	logic [7:0] sy_sh;
	logic [3:0] sy_cnt;
	logic sy_data;
	logic [3:0] tx_div;
	logic tx_busy;
	logic [10:0] tx_sh;
	logic [3:0] tx_cnt;
	logic tx_line;
	fmsp_pkg::fmsp_rx_st_t rx_st;
	logic [3:0] rx_div;
	logic [3:0] rx_cnt;
	logic [8:0] rx_sh;
	logic [1:0] smp;
	logic rx_prev;
	logic txd_q;
	fmsp_rate_if rif();

	fmsp_rate_gen u_rate (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.rif(rif)
	);

	// Mode field decode
	wire fmsp_pkg::fmsp_mode_t mode =
		fmsp_pkg::fmsp_mode_t'({mode_select_high, mode_select_low});
	wire is_sync = (mode == fmsp_pkg::fmsp_mode_sync);
	wire is_m1 = (mode == fmsp_pkg::fmsp_mode_10);
	wire fe_sel = frame_error_access_select_i;
	assign rif.mode = mode;
	assign rif.fast = multiproc_rate_flag;
	assign rif.rate_double_bit = rate_double_bit_i;
	assign rif.ovf = timer_ovf_i;
	assign rif.run0 = (sy_st != fmsp_pkg::sync_idle);

	// Software access decode
	wire ctrl_hi_wr = ctrl_wr_i & ~fe_sel;
	wire fe_wr = ctrl_wr_i & fe_sel;
	wire bit7_rd = fe_sel ? frame_error_flag : mode_select_high;
	assign ctrl_rdata_o = {bit7_rd, mode_select_low, multiproc_rate_flag,
		receive_enable, transmit_ninth_bit, receive_ninth_bit,
		transmit_done_flag, receive_done_flag};
	assign buf_rdata_o = serial_buffer;

	// Synchronous mode decode
	wire sy_idle = (sy_st == fmsp_pkg::sync_idle);
	wire sy_start_tx = sy_idle & is_sync & buf_wr_i;
	wire sy_start_rx = sy_idle & is_sync & ~buf_wr_i & receive_enable &
		~receive_done_flag;
	wire sy_last = (sy_cnt == `FMSP_M0_LAST_BIT);
	wire sy_ti = (sy_st == fmsp_pkg::sync_tx) & rif.ph_end & sy_last;
	wire sy_ri = (sy_st == fmsp_pkg::sync_rx) & rif.ph_end & sy_last;

	// Asynchronous transmit decode
	wire tx_load = buf_wr_i & ~is_sync;
	wire tx_roll = rif.tick & (tx_div == `FMSP_DIV_LAST);
	wire [3:0] tx_last = is_m1 ? `FMSP_LAST_M1 : `FMSP_LAST_M23;
	wire tx_step = tx_roll & tx_busy & ~tx_load;
	wire tx_ti = tx_step & (tx_cnt == tx_last);
	wire [10:0] tx_frame = is_m1 ?
		{2'b11, buf_wdata_i, 1'b0} :
		{1'b1, transmit_ninth_bit, buf_wdata_i, 1'b0};

	// Asynchronous receive decode
	wire fall_det = rif.tick & rx_prev & ~rx_lvl;
	wire rx_start = (rx_st == fmsp_pkg::rx_hunt) & ~is_sync &
		receive_enable & fall_det;
	wire in_frame = (rx_st == fmsp_pkg::rx_frame);
	wire rx_vote_now = in_frame & rif.tick & (rx_div == `FMSP_SMP_C);
	wire vote = (smp[0] & smp[1]) | (smp[0] & rx_lvl) |
		(smp[1] & rx_lvl);
	wire [3:0] rx_last = is_m1 ? `FMSP_LAST_M1 : `FMSP_LAST_M23;
	wire bad_start = rx_vote_now & (rx_cnt == 4'h0) & vote;
	wire rx_end = rx_vote_now & (rx_cnt == rx_last);
	wire [7:0] rx_data = is_m1 ? rx_sh[8:1] : rx_sh[7:0];
	wire rx_nine = is_m1 ? vote : rx_sh[8];
	wire rx_keep = ~receive_done_flag &
		(~multiproc_rate_flag | rx_nine);
	wire rx_store = rx_end & rx_keep;
	wire fe_set = rx_end & ~vote;
	wire next_txd = is_sync ? ~rif.ph_low : tx_line;

	// Reset release, kept apart from the pin logic
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// Three stage pin capture; a change counts once stages agree
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_lvl <= 1'b1;
		end else begin
			rx_s1 <= rxd_i;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3)
				rx_lvl <= rx_s3;
		end
	end

	// Control bits written by software
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			{mode_select_high, mode_select_low, multiproc_rate_flag,
				receive_enable, transmit_ninth_bit} <= 5'h00;
		end else if (ctrl_wr_i) begin
			if (ctrl_hi_wr)
				mode_select_high <= ctrl_wdata_i[`FMSP_BIT_MODE_HI];
			mode_select_low <= ctrl_wdata_i[`FMSP_BIT_MODE_LO];
			multiproc_rate_flag <= ctrl_wdata_i[`FMSP_BIT_MPR];
			receive_enable <= ctrl_wdata_i[`FMSP_BIT_REN];
			transmit_ninth_bit <= ctrl_wdata_i[`FMSP_BIT_TB8];
		end
	end

	// Flags: a hardware set beats a software write in the same cycle
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			transmit_done_flag <= 1'b0;
			receive_done_flag <= 1'b0;
			frame_error_flag <= 1'b0;
			receive_ninth_bit <= 1'b0;
		end else begin
			if (sy_ti | tx_ti)
				transmit_done_flag <= 1'b1;
			else if (ctrl_wr_i)
				transmit_done_flag <= ctrl_wdata_i[`FMSP_BIT_TI];
			if (sy_ri | rx_store)
				receive_done_flag <= 1'b1;
			else if (ctrl_wr_i)
				receive_done_flag <= ctrl_wdata_i[`FMSP_BIT_RI];
			if (fe_set)
				frame_error_flag <= 1'b1;
			else if (fe_wr)
				frame_error_flag <= ctrl_wdata_i[`FMSP_BIT_MODE_HI];
			if (rx_store)
				receive_ninth_bit <= rx_nine;
			else if (ctrl_wr_i)
				receive_ninth_bit <= ctrl_wdata_i[`FMSP_BIT_RB8];
		end
	end

	// Receive buffer, read back by software
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n)
			serial_buffer <= `FMSP_BUF_RST;
		else if (sy_ri)
			serial_buffer <= sy_sh;
		else if (rx_store)
			serial_buffer <= rx_data;
	end

	// Mode 0 shifter; half duplex, so one sequencer serves both ways
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sy_st <= fmsp_pkg::sync_idle;
			sy_sh <= 8'h00;
			sy_cnt <= 4'h0;
			sy_data <= 1'b1;
		end else begin
			unique case (sy_st)
				fmsp_pkg::sync_idle: begin
					sy_cnt <= 4'h0;
					if (sy_start_tx) begin
						sy_sh <= buf_wdata_i;
						sy_st <= fmsp_pkg::sync_tx;
					end else if (sy_start_rx) begin
						sy_st <= fmsp_pkg::sync_rx;
					end
				end
				fmsp_pkg::sync_tx: begin
					if (rif.ph_out)
						sy_data <= sy_sh[0];
					if (rif.ph_end) begin
						sy_sh <= {1'b0, sy_sh[7:1]};
						sy_cnt <= sy_cnt + 4'h1;
						if (sy_last)
							sy_st <= fmsp_pkg::sync_idle;
					end
				end
				fmsp_pkg::sync_rx: begin
					if (rif.ph_rise)
						sy_sh <= {rx_lvl, sy_sh[7:1]};
					if (rif.ph_end) begin
						sy_cnt <= sy_cnt + 4'h1;
						if (sy_last)
							sy_st <= fmsp_pkg::sync_idle;
					end
				end
			endcase
		end
	end

	// Transmit divider runs free so frames align to its rollovers
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_div <= 4'h0;
			tx_busy <= 1'b0;
			tx_sh <= 11'h7ff;
			tx_cnt <= 4'h0;
			tx_line <= 1'b1;
		end else begin
			if (rif.tick)
				tx_div <= tx_div + 4'h1;
			if (tx_load) begin
				tx_sh <= tx_frame;
				tx_cnt <= 4'h0;
				tx_busy <= 1'b1;
			end else if (tx_step) begin
				tx_line <= tx_sh[0];
				tx_sh <= {1'b1, tx_sh[10:1]};
				tx_cnt <= tx_cnt + 4'h1;
				if (tx_cnt == tx_last)
					tx_busy <= 1'b0;
			end
		end
	end

	// Asynchronous receiver
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_st <= fmsp_pkg::rx_hunt;
			rx_div <= 4'h0;
			rx_cnt <= 4'h0;
			rx_sh <= 9'h000;
			smp <= 2'b11;
			rx_prev <= 1'b1;
		end else begin
			if (rif.tick)
				rx_prev <= rx_lvl;
			if (rx_start) begin
				rx_st <= fmsp_pkg::rx_frame;
				rx_div <= 4'h0;
				rx_cnt <= 4'h0;
			end else if (in_frame && rif.tick) begin
				rx_div <= rx_div + 4'h1;
				if (rx_div == `FMSP_SMP_A)
					smp[0] <= rx_lvl;
				if (rx_div == `FMSP_SMP_B)
					smp[1] <= rx_lvl;
				if (bad_start || rx_end) begin
					rx_st <= fmsp_pkg::rx_hunt;
				end else if (rx_vote_now) begin
					if (rx_cnt != 4'h0)
						rx_sh <= {vote, rx_sh[8:1]};
					rx_cnt <= rx_cnt + 4'h1;
				end
			end
		end
	end

	// Pin outputs from flops; shift clock and data share one cycle of lag
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n)
			txd_q <= 1'b1;
		else
			txd_q <= next_txd;
	end
	assign txd_o = txd_q;
	assign rxd_o = sy_data;
	assign rxd_oe_o = (sy_st == fmsp_pkg::sync_tx);
endmodule // fmsp_serial_port

// ### rtl/fmsp_consts.svh
// Constants of the four mode serial port
// How it works
// - One buffer address: writes load transmitter, reads return receive buffer.
// - Mode 0 shifts eight bits LSB first on rxd, clock on txd.
// - Mode 0 shift rate is clock/12, or clock/4 with rate flag set.
// - Mode 0 data leads falling clock 1 or 3 clocks; low 2 or 6.
// - Mode 0 transmit sets transmit-done after the last bit.
// - Mode 0 receive starts if enabled and receive-done clear; samples rising.
// - After eighth rising edge set receive-done; halt until software clears.
// - Mode 1 frame: start 0, eight data LSB first, stop 1 to ninth flag.
// - Mode 1 bit rate is timer overflow rate /16 or /32.
// - Async transmit waits for divide-by-16 rollovers, one bit per rollover.
// - Transmit-done at rollover ten (mode 1) or eleven (modes 2, 3).
// - Receive line watched at 16x rate; falling edge resets counter.
// - Each async bit is a majority of samples at states 7, 8, 9.
// - A start bit voted one aborts reception and resumes edge search.
// - Frame stored only if receive-done clear and multiproc flag rule passes.
// - Edge search resumes in the middle of the stop bit.
// - Mode 2 frame adds transmit ninth bit; received ninth bit stored.
// - Mode 2 bit rate is clock /16 or /32 by rate doubling bit.
// - Mode 3 equals mode 2 but runs from timer overflows.
// - Missing stop bit sets sticky frame error; only software clears it.
// - Control bit 7 reaches frame error or mode high bit by select.
`ifndef FMSP_CONSTS_SVH
`define FMSP_CONSTS_SVH
`define FMSP_BIT_MODE_HI 7
`define FMSP_BIT_MODE_LO 6
`define FMSP_BIT_MPR 5
`define FMSP_BIT_REN 4
`define FMSP_BIT_TB8 3
`define FMSP_BIT_RB8 2
`define FMSP_BIT_TI 1
`define FMSP_BIT_RI 0
`define FMSP_CTRL_RST 8'h00
`define FMSP_BUF_RST 8'h00
`define FMSP_M0_PER_SLOW 4'hc
`define FMSP_M0_FALL_SLOW 4'h3
`define FMSP_M0_LOW_SLOW 4'h6
`define FMSP_M0_PER_FAST 4'h4
`define FMSP_M0_FALL_FAST 4'h1
`define FMSP_M0_LOW_FAST 4'h2
`define FMSP_M0_LAST_BIT 4'h7
`define FMSP_DIV_LAST 4'hf
`define FMSP_SMP_A 4'h7
`define FMSP_SMP_B 4'h8
`define FMSP_SMP_C 4'h9
`define FMSP_LAST_M1 4'h9
`define FMSP_LAST_M23 4'ha
`endif

// ### rtl/fmsp_pkg.sv
// Types of the four mode serial port
package fmsp_pkg;
	typedef enum logic [1:0] {
		fmsp_mode_sync,
		fmsp_mode_10,
		fmsp_mode_11f,
		fmsp_mode_11t
	} fmsp_mode_t;
	typedef enum logic [1:0] {sync_idle, sync_tx, sync_rx} fmsp_sync_st_t;
	typedef enum logic {rx_hunt, rx_frame} fmsp_rx_st_t;
endpackage

// ### rtl/fmsp_rate_if.sv
// Rate signals between port core and rate generator
`timescale 1ns/1ps
interface fmsp_rate_if;
	fmsp_pkg::fmsp_mode_t mode;
	logic fast;
	logic rate_double_bit;
	logic ovf;
	logic run0;
	logic tick;
	logic ph_out;
	logic ph_low;
	logic ph_rise;
	logic ph_end;
	modport gen(input mode, fast, rate_double_bit, ovf, run0,
		output tick, ph_out, ph_low, ph_rise, ph_end);
	modport core(output mode, fast, rate_double_bit, ovf, run0,
		input tick, ph_out, ph_low, ph_rise, ph_end);
endinterface

// ### rtl/fmsp_rate_gen.sv
// Mode 0 shift phase and 16x asynchronous tick generator
`timescale 1ns/1ps
`include "fmsp_consts.svh"
module fmsp_rate_gen (
	input wire logic clock_i,
	input wire logic rst_n_i,
	fmsp_rate_if.gen rif
);
	logic [3:0] phase;
	logic clk_half;
	logic ovf_half;
	wire [3:0] per = rif.fast ? `FMSP_M0_PER_FAST : `FMSP_M0_PER_SLOW;
	wire [3:0] fall = rif.fast ? `FMSP_M0_FALL_FAST : `FMSP_M0_FALL_SLOW;
	wire [3:0] low = rif.fast ? `FMSP_M0_LOW_FAST : `FMSP_M0_LOW_SLOW;
	wire [3:0] rise = fall + low;
	wire ovf_tick = rif.rate_double_bit ? rif.ovf : (rif.ovf & ovf_half);
	wire osc_tick = rif.rate_double_bit | clk_half;
	assign rif.ph_out = rif.run0 && (phase == 4'h0);
	assign rif.ph_low = rif.run0 && (phase >= fall) && (phase < rise);
	assign rif.ph_rise = rif.run0 && (phase == rise);
	assign rif.ph_end = rif.run0 && (phase == per - 4'h1);
	// Timer modes share one source, fixed mode uses the clock
	assign rif.tick = (rif.mode == fmsp_pkg::fmsp_mode_11f) ? osc_tick :
		(rif.mode == fmsp_pkg::fmsp_mode_sync) ? 1'b0 : ovf_tick;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase <= 4'h0;
			clk_half <= 1'b0;
			ovf_half <= 1'b0;
		end else begin
			clk_half <= ~clk_half;
			if (rif.ovf)
				ovf_half <= ~ovf_half;
			if (!rif.run0 || rif.ph_end)
				phase <= 4'h0;
			else
				phase <= phase + 4'h1;
		end
	end
endmodule // fmsp_rate_gen

// ### verification/fmsp_serial_port_assertions.sv
// Port assertions of the four mode serial port
`timescale 1ns/1ps
module fmsp_serial_port_assertions (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic buf_wr_i,
	input wire logic [7:0] buf_wdata_i,
	input wire logic [7:0] buf_rdata_o,
	input wire logic ctrl_wr_i,
	input wire logic [7:0] ctrl_wdata_i,
	input wire logic [7:0] ctrl_rdata_o,
	input wire logic rate_double_bit_i,
	input wire logic frame_error_access_select_i,
	input wire logic timer_ovf_i,
	input wire logic rxd_i,
	input wire logic rxd_o,
	input wire logic rxd_oe_o,
	input wire logic txd_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	wire logic sel = frame_error_access_select_i;
	wire logic fast = ctrl_rdata_o[5];
	property p_oe_mode;
		rxd_oe_o |-> !ctrl_rdata_o[6] && (sel || !ctrl_rdata_o[7]);
	endproperty
	a_oe_mode: assert property (p_oe_mode)
		else $error("rxd driven outside mode 0");
	property p_m0_fast;
		$fell(txd_o) && rxd_oe_o && fast |->
			(!txd_o && $stable(rxd_o))[*2] ##1 (txd_o && $stable(rxd_o));
	endproperty
	a_m0_fast: assert property (p_m0_fast)
		else $error("fast shift clock low phase wrong");
	property p_m0_slow;
		$fell(txd_o) && rxd_oe_o && !fast |->
			(!txd_o && $stable(rxd_o))[*6] ##1 (txd_o && $stable(rxd_o));
	endproperty
	a_m0_slow: assert property (p_m0_slow)
		else $error("slow shift clock low phase wrong");
	property p_tx_done_line;
		$rose(ctrl_rdata_o[1]) |-> ##2 txd_o;
	endproperty
	a_tx_done_line: assert property (p_tx_done_line)
		else $error("transmit done before line idle");
	property p_err_sticky;
		sel && $past(sel) && !$past(ctrl_wr_i) && $past(ctrl_rdata_o[7])
			|-> ctrl_rdata_o[7];
	endproperty
	a_err_sticky: assert property (p_err_sticky)
		else $error("frame error flag dropped");
	property p_b7_mode;
		ctrl_wr_i && !sel ##1 !sel |-> ctrl_rdata_o[7] == $past(ctrl_wdata_i[7]);
	endproperty
	a_b7_mode: assert property (p_b7_mode)
		else $error("bit 7 write lost");
	property p_buf_rx_done;
		!$stable(buf_rdata_o) |-> $rose(ctrl_rdata_o[0]);
	endproperty
	a_buf_rx_done: assert property (p_buf_rx_done)
		else $error("buffer changed without receive done");
	property p_m0_halt;
		!sel && ctrl_rdata_o[7:6] == 2'b00 && ctrl_rdata_o[0]
			&& $past(ctrl_rdata_o[0]) && !rxd_oe_o |-> txd_o;
	endproperty
	a_m0_halt: assert property (p_m0_halt)
		else $error("shift clock runs while receive done");
endmodule // fmsp_serial_port_assertions

bind fmsp_serial_port fmsp_serial_port_assertions u_fmsp_serial_port_assertions (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .buf_wr_i(buf_wr_i),
	.buf_wdata_i(buf_wdata_i), .buf_rdata_o(buf_rdata_o),
	.ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
	.ctrl_rdata_o(ctrl_rdata_o), .rate_double_bit_i(rate_double_bit_i),
	.frame_error_access_select_i(frame_error_access_select_i),
	.timer_ovf_i(timer_ovf_i), .rxd_i(rxd_i), .rxd_o(rxd_o),
	.rxd_oe_o(rxd_oe_o), .txd_o(txd_o));

// ### verification/fmsp_far_end.sv
// Far-end serial device model
`timescale 1ns/1ps
module fmsp_far_end (
	input wire logic clock_i,
	input wire logic txd_i,
	input wire logic line_i,
	output logic drive_o
);
	logic [7:0] src = 8'hff;
	logic [7:0] got = 8'h00;
	int idx = 0;
	int cyc = 0;
	int last = 0;
	int per = 0;
	int bit_clk = 32;
	logic line_q = 1'b1;
	initial drive_o = 1'b1;
	// Counted and sampled off the falling edge, so pin updates settle first
	always @(negedge clock_i) begin
		cyc <= cyc + 1;
		line_q <= line_i;
	end
	// Change data only as the shift clock falls
	always @(negedge txd_i) begin
		drive_o <= src[idx[2:0]];
		per <= cyc - last;
		last <= cyc;
	end
	always @(posedge txd_i) begin
		got <= {line_q, got[7:1]};
		idx <= idx + 1;
		// Line rests high after the eighth bit, as its pull-up would hold it
		if (idx[2:0] == 3'h7)
			drive_o <= 1'b1;
	end
	task automatic m0_load(input logic [7:0] v);
		src = v;
		idx = 0;
	endtask
	// Eleven bits of bit_clk clocks each, then one idle bit
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			drive_o = f[i];
			repeat (bit_clk) @(negedge clock_i);
		end
		drive_o = 1'b1;
		repeat (bit_clk) @(negedge clock_i);
	endtask
	// Mid-bit sampling; bit 10 reads idle in 10-bit frames
	task automatic catch(output logic [10:0] v);
		@(negedge txd_i);
		repeat (bit_clk / 2) @(negedge clock_i);
		for (int i = 0; i < 11; i++) begin
			v[i] = txd_i;
			repeat (bit_clk) @(negedge clock_i);
		end
	endtask
endmodule // fmsp_far_end

// ### verification/fmsp_serial_port_bench.sv
// Self-checking bench of the four mode serial port
`timescale 1ns/1ps
module fmsp_serial_port_bench;
	logic clock_i, rst_n_i, bwr, cwr, dbl, sel, ovf, rxd_o, oe, txd_o, drv, nb;
	logic [7:0] bwd, cwd, brd, crd, m;
	logic [10:0] v;
	logic [7:0] md [3] = '{8'h50, 8'h98, 8'hd8};
	int fails = 0;
	int checked = 0;
	wire logic line = oe ? rxd_o : drv;
	fmsp_serial_port u_fmsp_serial_port (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.buf_wr_i(bwr), .buf_wdata_i(bwd), .buf_rdata_o(brd), .ctrl_wr_i(cwr),
		.ctrl_wdata_i(cwd), .ctrl_rdata_o(crd), .rate_double_bit_i(dbl),
		.frame_error_access_select_i(sel), .timer_ovf_i(ovf), .rxd_i(line),
		.rxd_o(rxd_o), .rxd_oe_o(oe), .txd_o(txd_o));
	fmsp_far_end u_fmsp_far_end (.clock_i(clock_i), .txd_i(txd_o),
		.line_i(line), .drive_o(drv));
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	// Overflow every second clock: 32 clocks a bit
	always @(negedge clock_i) ovf <= !(ovf === 1'b1);
	initial begin
		#1000000;
		fails++;
		end_of_test;
	end
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic c, input logic [7:0] d);
		@(negedge clock_i);
		cwr = c;
		bwr = !c;
		cwd = d;
		bwd = d;
		@(negedge clock_i);
		cwr = 1'b0;
		bwr = 1'b0;
	endtask
	task automatic wait_bit(input int b);
		for (int n = 0; n < 1500 && crd[b] !== 1'b1; n++) begin
			@(negedge clock_i);
		end
	endtask
	task automatic end_of_test;
		if (fails == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		rst_n_i = 1'b0;
		{bwr, cwr, sel, bwd, cwd} = 19'h00000;
		dbl = 1'b1;
		repeat (8) @(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clock_i);
		check({crd, txd_o, rxd_o, oe}, 11'h006);
		for (int k = 0; k < 2; k++) begin
			wr(1'b1, k ? 8'h00 : 8'h20);
			wr(1'b0, md[k]);
			wait_bit(1);
			check(crd[1], 1'b1);
			check(u_fmsp_far_end.got, md[k]);
			check(u_fmsp_far_end.per[10:0], k ? 11'h00c : 11'h004);
		end
		u_fmsp_far_end.m0_load(8'h5a);
		wr(1'b1, 8'h10);
		wait_bit(0);
		check(brd, 8'h5a);
		repeat (40) @(negedge clock_i);
		check(txd_o, 1'b1);
		wr(1'b1, 8'h00);
		u_fmsp_far_end.m0_load(8'hff);
		// Modes 1, 2, 3 at 32 clocks a bit, then mode 1 slow, mode 2 fast
		for (int k = 0; k < 5; k++) begin
			m = md[k % 3];
			dbl = (k % 2 == 0);
			nb = (k != 1);
			u_fmsp_far_end.bit_clk = (k == 3) ? 64 : (k == 4) ? 16 : 32;
			wr(1'b1, m);
			fork
				wr(1'b0, m ^ 8'h3c);
				u_fmsp_far_end.catch(v);
			join
			check(v, {2'b11, m ^ 8'h3c, 1'b0});
			wait_bit(1);
			check(crd[1], 1'b1);
			u_fmsp_far_end.send({1'b1, nb, m ^ 8'hc3, 1'b0});
			check({brd, crd[2]}, {m ^ 8'hc3, nb});
		end
		u_fmsp_far_end.send({2'b11, 8'h11, 1'b0});
		check(brd, 8'h5b);
		u_fmsp_far_end.bit_clk = 32;
		wr(1'b1, 8'hf8);
		u_fmsp_far_end.send({2'b10, 8'h22, 1'b0});
		check(crd[0], 1'b0);
		u_fmsp_far_end.drive_o = 1'b0;
		repeat (4) @(negedge clock_i);
		u_fmsp_far_end.drive_o = 1'b1;
		repeat (40) @(negedge clock_i);
		u_fmsp_far_end.send({2'b11, 8'h77, 1'b0});
		check(brd, 8'h77);
		wr(1'b1, 8'hd8);
		sel = 1'b1;
		u_fmsp_far_end.send({2'b01, 8'h33, 1'b0});
		@(negedge clock_i);
		check(crd[7], 1'b1);
		wr(1'b1, 8'hd8);
		u_fmsp_far_end.send({2'b11, 8'h44, 1'b0});
		@(negedge clock_i);
		check({crd[7], brd}, {1'b1, 8'h44});
		wr(1'b1, 8'h58);
		check(crd[7], 1'b0);
		sel = 1'b0;
		@(negedge clock_i);
		check(crd[7], 1'b1);
		end_of_test;
	end
endmodule // fmsp_serial_port_bench
